// [hw/ebi_map.svh]
// Purpose: constants of the external memory bus interface
// Assumes: register byte address is four times its index
// Notes: included by every design file of the block except the package
// Behaviour
// [RULE1] Everything stays in reset while the active-low reset is low.
// [RULE2] Boot pin low gives single-chip mode, high gives external bus mode.
// [RULE3] Region 3 bus is 16 bits with width pin low, 8 bits high.
// [RULE4] Separate mode: low lanes carry data 0-7, high lanes 8-15 on 16-bit bus.
// [RULE5] Address bits 0 to 22 are driven uninverted during external accesses.
// [RULE6] Address bit 23 is driven inverted.
// [RULE7] Multiplexed mode: low lanes carry address 0-7, then data 0-7.
// [RULE8] 16-bit multiplexed mode: high lanes carry address 8-15, then data 8-15.
// [RULE9] Four region selects, each low for accesses to its own space.
// [RULE10] Software picks byte store strobes or single strobe plus upper byte enable.
// [RULE11] Byte scheme, 16-bit bus: low strobe writes even, high strobe odd.
// [RULE12] External data is read while the read strobe is low.
// [RULE13] Single scheme: low store strobe writes, low upper enable marks odd access.
// [RULE14] Software uses the single strobe scheme whenever the bus is 8 bits.
// [RULE15] An address latch strobe lets external logic latch the address.
// [RULE16] Master holds takeover request low; device stays in hold meanwhile.
// [RULE17] Bus released acknowledge is low for the whole hold state.
// [RULE18] Wait request low keeps the current bus cycle waiting.
// [RULE19] In hold, address, data and strobe outputs are released.
// [RULE20] Wait and hold are synchronised; hold waits for the cycle to end.
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH
`define EBI_NREG          6
`define EBI_CTRL_IDX      6'h00
`define EBI_ADDR_IDX      6'h01
`define EBI_WDATA_IDX     6'h02
`define EBI_CMD_IDX       6'h03
`define EBI_STATUS_IDX    6'h04
`define EBI_RDATA_IDX     6'h05
`define EBI_CTRL_RESET    3'h4
`define EBI_CTRL_SINGLE   0
`define EBI_CTRL_MUX      1
`define EBI_CTRL_WIDE     2
`define EBI_CMD_WRITE     0
`define EBI_CMD_WORD      1
`define EBI_CMD_REG_LSB   2
`define EBI_REGION3       2'h3
`define EBI_STROBE_MIN    6
`define EBI_SETTLE        3'h5
`define EBI_SYNC_RESET    20'h30000
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2
`endif

// [hw/ebi_pkg.sv]
// Purpose: types of the external memory bus interface
// Assumes: constants live in ebi_map.svh
// Notes: pin group travels as one packed struct
package ebi_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_RECOVER, ST_HOLD} ebi_state_t;

	typedef struct packed {
		logic [22:0] addr;
		logic        top_address_bit;
		logic [3:0]  region_select_n;
		logic        read_strobe_n;
		logic        low_byte_store_strobe_n;
		logic        high_byte_store_strobe_n;
		logic        addr_latch_strobe;
		logic        bus_released_ack_n;
	} ext_out_t;

	typedef struct packed {
		logic        write;
		logic        word;
		logic [1:0]  region;
		logic [23:0] addr;
		logic [15:0] wdata;
	} access_t;

	typedef struct packed {
		logic        en;
		logic [5:0]  idx;
		logic [31:0] data;
		logic [3:0]  strb;
	} reg_wr_t;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

// [hw/ebi_sync.sv]
// Purpose: three-stage input synchroniser, one chain per bit
// Assumes: inputs are asynchronous to aclk
// Notes: output follows only when stages two and three agree
`include "ebi_map.svh"
module ebi_sync import ebi_pkg::*; #(
	parameter int          W         = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			logic s1, s2, s3;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1      <= RESET_VAL[i];
					s2      <= RESET_VAL[i];
					s3      <= RESET_VAL[i];
					dout[i] <= RESET_VAL[i];
				end else begin
					s1 <= din[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						dout[i] <= s3;
					end
				end
			end
		end
	endgenerate
endmodule

// [hw/ebi_axil_slave.sv]
// Purpose: AXI4-Lite slave feeding a word-indexed register file
// Assumes: one write and one read in flight at most
// Notes: unmapped index answers SLVERR, reads zero
`include "ebi_map.svh"
module ebi_axil_slave import ebi_pkg::*; #(
	parameter int AW   = 8,
	parameter int NREG = `EBI_NREG
) (
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// write channels
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	// read channels
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// register side
	output reg_wr_t            reg_wr,
	output logic [5:0]         rd_idx,
	input  wire logic [31:0]   rd_data
);
	if (AW != 8) begin : g_chk
		$error("ebi_axil_slave: AW must be 8");
	end

	logic        aw_held;
	logic        w_held;
	logic [5:0]  aw_idx;
	logic [31:0] wd;
	logic [3:0]  ws;
	logic        aw_hit;
	logic        ar_hit;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx        = s_axi_araddr[AW-1:2];
	assign aw_hit        = aw_idx < 6'(NREG);
	assign ar_hit        = rd_idx < 6'(NREG);
	assign reg_wr        = '{en: aw_held && w_held && aw_hit, idx: aw_idx, data: wd, strb: ws};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_idx       <= '0;
			wd           <= '0;
			ws           <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_idx  <= s_axi_awaddr[AW-1:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wd     <= s_axi_wdata;
				ws     <= s_axi_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= aw_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= ar_hit ? rd_data : '0;
			s_axi_rresp  <= ar_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// [hw/external_memory_bus_interface.sv]
// Purpose: external memory bus master driven from AXI4-Lite registers
// Assumes: pins resolved outside from the enables; inputs are asynchronous
// Notes: one access per command write; outputs lag state by one cycle
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "ebi_map.svh"
module external_memory_bus_interface import ebi_pkg::*; #(
	parameter int STROBE_MIN = `EBI_STROBE_MIN
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// register bus
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// straps
	input  wire logic        boot_mode_pin,
	input  wire logic        byte_width_pin,
	// bus control inputs
	input  wire logic        hold_request_n,
	input  wire logic        wait_request_n,
	// bus pins
	output ext_out_t         pins,
	output logic             bus_oe,
	input  wire logic [15:0] data_in,
	output logic [15:0]      data_out,
	output logic [1:0]       data_oe
);
	if (STROBE_MIN < 5 || STROBE_MIN > 15) begin : g_chk
		$error("external_memory_bus_interface: STROBE_MIN must be 5..15");
	end

	logic        boot_s;
	logic        byte_s;
	logic        hold_s_n;
	logic        wait_s_n;
	logic [15:0] din_s;
	reg_wr_t     reg_wr;
	logic [5:0]  rd_idx;
	logic [31:0] rd_data;
	logic [2:0]  ctrl;
	logic [23:0] acc_addr;
	logic [15:0] acc_wdata;
	access_t     acc;
	logic        pending;
	logic [15:0] rd_result;
	ebi_state_t  state;
	ebi_state_t  next_state;
	logic [3:0]  strobe_cnt;
	logic [2:0]  settle_cnt;
	logic        micro_mode;
	logic        bus16;
	logic        word_eff;
	logic [1:0]  lane_en;
	logic        ube_n;
	logic        busy;
	logic        cmd_wr;
	logic        strobe_done;
	ext_out_t    next_pins;
	logic        next_bus_oe;
	logic [15:0] next_data_out;
	logic [1:0]  next_data_oe;
	logic [15:0] wlanes;

	ebi_sync #(.W(20), .RESET_VAL(`EBI_SYNC_RESET)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     ({boot_mode_pin, byte_width_pin, hold_request_n, wait_request_n, data_in}),
		.dout    ({boot_s, byte_s, hold_s_n, wait_s_n, din_s})
	); // [RULE20]

	ebi_axil_slave #(.AW(8), .NREG(`EBI_NREG)) u_regs (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.reg_wr        (reg_wr),
		.rd_idx        (rd_idx),
		.rd_data       (rd_data)
	);

	// boot mode caught once the synchroniser has settled after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_cnt <= '0;
			micro_mode <= 1'b0;
		end else if (settle_cnt != `EBI_SETTLE) begin
			settle_cnt <= settle_cnt + 3'h1;
			if (settle_cnt == `EBI_SETTLE - 3'h1) begin
				micro_mode <= boot_s; // [RULE2]
			end
		end
	end

	// configuration and access staging registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl      <= `EBI_CTRL_RESET;
			acc_addr  <= '0;
			acc_wdata <= '0;
		end else if (reg_wr.en) begin
			unique case (reg_wr.idx)
				`EBI_CTRL_IDX: ctrl <= 3'(merge_bytes(32'(ctrl), reg_wr.data, reg_wr.strb)); // [RULE10]
				`EBI_ADDR_IDX: acc_addr <= 24'(merge_bytes(32'(acc_addr), reg_wr.data,
					reg_wr.strb));
				`EBI_WDATA_IDX: acc_wdata <= 16'(merge_bytes(32'(acc_wdata), reg_wr.data,
					reg_wr.strb));
				default: ;
			endcase
		end
	end

	assign busy   = pending || state == ST_ADDR || state == ST_STROBE || state == ST_RECOVER;
	assign cmd_wr = reg_wr.en && reg_wr.idx == `EBI_CMD_IDX && reg_wr.strb[0];

	// command launch; refused while busy or in single-chip mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending <= 1'b0;
			acc     <= '0;
		end else if (cmd_wr && !busy && micro_mode) begin
			pending      <= 1'b1;
			acc.write    <= reg_wr.data[`EBI_CMD_WRITE];
			acc.word     <= reg_wr.data[`EBI_CMD_WORD];
			acc.region   <= reg_wr.data[`EBI_CMD_REG_LSB +: 2];
			acc.addr     <= acc_addr;
			acc.wdata    <= acc_wdata;
		end else if (state == ST_IDLE && next_state == ST_ADDR) begin
			pending <= 1'b0;
		end
	end

	assign bus16    = (acc.region == `EBI_REGION3) ? !byte_s : ctrl[`EBI_CTRL_WIDE]; // [RULE3]
	assign word_eff = acc.word && bus16;
	assign lane_en  = !bus16 ? 2'h1 : word_eff ? 2'h3 : acc.addr[0] ? 2'h2 : 2'h1; // [RULE4]
	assign ube_n    = bus16 ? !lane_en[1] : !acc.addr[0]; // [RULE13]
	assign wlanes   = word_eff ? acc.wdata : {acc.wdata[7:0], acc.wdata[7:0]};
	assign strobe_done = strobe_cnt >= 4'(STROBE_MIN - 1);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (micro_mode && !hold_s_n) begin
					next_state = ST_HOLD; // [RULE20]
				end else if (micro_mode && pending) begin
					next_state = ST_ADDR;
				end
			end
			ST_ADDR: next_state = ST_STROBE;
			ST_STROBE: begin
				if (strobe_done && wait_s_n) begin
					next_state = ST_RECOVER; // [RULE18]
				end
			end
			ST_RECOVER: next_state = ST_IDLE;
			ST_HOLD: begin
				if (hold_s_n) begin
					next_state = ST_IDLE; // [RULE16]
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE; // [RULE1]
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strobe_cnt <= '0;
		end else if (state == ST_STROBE && !strobe_done) begin
			strobe_cnt <= strobe_cnt + 4'h1;
		end else if (state != ST_STROBE) begin
			strobe_cnt <= '0;
		end
	end

	// read data taken at the end of the strobe, placed in the low bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_result <= '0;
		end else if (state == ST_STROBE && next_state == ST_RECOVER && !acc.write) begin
			if (word_eff) begin
				rd_result <= din_s; // [RULE12]
			end else if (lane_en[1]) begin
				rd_result <= {8'h00, din_s[15:8]};
			end else begin
				rd_result <= {8'h00, din_s[7:0]};
			end
		end
	end

	always_comb begin
		rd_data = '0;
		unique case (rd_idx)
			`EBI_CTRL_IDX: rd_data[2:0] = ctrl;
			`EBI_ADDR_IDX: rd_data[23:0] = acc_addr;
			`EBI_WDATA_IDX: rd_data[15:0] = acc_wdata;
			`EBI_STATUS_IDX: rd_data[3:0] = {!byte_s, micro_mode, state == ST_HOLD, busy};
			`EBI_RDATA_IDX: rd_data[15:0] = rd_result;
			default: rd_data = '0;
		endcase
	end

	// pin values for the next cycle
	always_comb begin
		next_pins                    = pins;
		next_pins.addr               = acc.addr[22:0]; // [RULE5]
		next_pins.top_address_bit    = !acc.addr[23]; // [RULE6]
		next_pins.region_select_n    = 4'hF;
		next_pins.read_strobe_n      = 1'b1;
		next_pins.low_byte_store_strobe_n  = 1'b1;
		next_pins.high_byte_store_strobe_n = 1'b1;
		next_pins.addr_latch_strobe  = 1'b0;
		next_pins.bus_released_ack_n = state != ST_HOLD; // [RULE17]
		next_bus_oe                  = micro_mode && state != ST_HOLD; // [RULE19]
		next_data_out                = data_out;
		next_data_oe                 = 2'h0;
		if (state == ST_ADDR || state == ST_STROBE || state == ST_RECOVER) begin
			next_pins.region_select_n[acc.region] = 1'b0; // [RULE9]
			if (ctrl[`EBI_CTRL_SINGLE]) begin
				next_pins.high_byte_store_strobe_n = ube_n; // [RULE13]
			end
		end
		if (state == ST_ADDR) begin
			next_pins.addr_latch_strobe = 1'b1; // [RULE15]
			if (ctrl[`EBI_CTRL_MUX]) begin
				next_data_out[7:0] = acc.addr[7:0]; // [RULE7]
				next_data_oe[0]    = 1'b1;
				if (bus16) begin
					next_data_out[15:8] = acc.addr[15:8]; // [RULE8]
					next_data_oe[1]     = 1'b1;
				end
			end
		end
		if (state == ST_STROBE && !acc.write) begin
			next_pins.read_strobe_n = 1'b0; // [RULE12]
		end
		if (state == ST_STROBE && acc.write) begin
			if (ctrl[`EBI_CTRL_SINGLE]) begin
				next_pins.low_byte_store_strobe_n = 1'b0; // [RULE13]
			end else begin
				next_pins.low_byte_store_strobe_n  = !lane_en[0]; // [RULE11]
				next_pins.high_byte_store_strobe_n = !lane_en[1];
			end
		end
		if ((state == ST_STROBE || state == ST_RECOVER) && acc.write) begin
			next_data_out = wlanes; // [RULE4] [RULE7] [RULE8]
			next_data_oe  = lane_en;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins.addr                     <= '0;
			pins.top_address_bit          <= 1'b1;
			pins.region_select_n          <= 4'hF;
			pins.read_strobe_n            <= 1'b1;
			pins.low_byte_store_strobe_n  <= 1'b1;
			pins.high_byte_store_strobe_n <= 1'b1;
			pins.addr_latch_strobe        <= 1'b0;
			pins.bus_released_ack_n       <= 1'b1;
			bus_oe                        <= 1'b0;
			data_out                      <= '0;
			data_oe                       <= 2'h0;
		end else begin
			pins     <= next_pins;
			bus_oe   <= next_bus_oe;
			data_out <= next_data_out;
			data_oe  <= next_data_oe;
		end
	end
endmodule

// [tb/ext_mem_model.sv]
// Purpose: external memory on the far side of the bus pins
// Assumes: bench tells the model the strobe scheme and bus width
// Notes: wait stretch length set by slow, zero for a prompt answer
module ext_mem_model import ebi_pkg::*; (
	// bus side
	input  wire logic        aclk,
	input  wire ext_out_t    pins,
	input  wire logic [15:0] data_out,
	input  wire logic [1:0]  data_oe,
	output logic [15:0]      mem_q,
	output logic             wait_request_n,
	// scenario controls
	input  wire logic        single,
	input  wire logic        wide,
	input  wire logic [3:0]  slow
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	logic [7:0] a;
	logic [4:0] wcnt;
	logic       strb;
	logic       wr_lo;
	logic       wr_hi;
	logic [15:0] idle_q;
	assign strb = !pins.read_strobe_n || !pins.low_byte_store_strobe_n
		|| (!pins.high_byte_store_strobe_n && !single);
	assign wr_lo = !pins.low_byte_store_strobe_n && !a[0];
	assign wr_hi = single ? !pins.low_byte_store_strobe_n && !pins.high_byte_store_strobe_n
		: !pins.high_byte_store_strobe_n;
	// held low for the first slow cycles of each strobe
	assign wait_request_n = !(strb && wcnt < {1'h0, slow});
	// stored data as soon as the read strobe falls (low lane only when narrow), changing lanes otherwise
	assign mem_q = pins.read_strobe_n ? idle_q
		: wide ? {mem[a | 8'h01], mem[a & 8'hFE]} : {~idle_q[15:8], mem[a]};
	initial begin
		idle_q = 16'h5A0F;
		wcnt = 5'h00;
	end
	always @(posedge aclk) begin
		wcnt <= strb ? wcnt + 5'h01 : 5'h00;
		if (pins.addr_latch_strobe) begin
			a <= data_oe[0] ? data_out[7:0] : pins.addr[7:0];
		end
		idle_q <= ~idle_q;
		if (wide && wr_lo) begin
			mem[a] <= data_out[7:0];
		end
		if (wide && wr_hi) begin
			mem[a | 8'h01] <= data_out[15:8];
		end
		if (!wide && !pins.low_byte_store_strobe_n) begin
			mem[a] <= data_out[7:0];
		end
	end
endmodule

// [tb/ebi_monitor.sv]
// Purpose: pin-level checks on the external memory bus interface
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound into external_memory_bus_interface by the bind below
module ebi_monitor import ebi_pkg::*; #(
	parameter int STROBE_MIN = 6
) (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// bus control and pins
	input wire logic       hold_request_n,
	input wire logic       wait_request_n,
	input wire ext_out_t   pins,
	input wire logic       bus_oe,
	input wire logic [1:0] data_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic       strb;
	logic [4:0] slen;
	assign strb = !pins.read_strobe_n || !pins.low_byte_store_strobe_n;
	// consecutive cycles with the read or low byte store strobe low
	always_ff @(posedge aclk) begin
		if (!aresetn || !strb) begin
			slen <= 5'h00;
		end else if (slen != 5'h1F) begin
			slen <= slen + 5'h01;
		end
	end
	a_ale_one_cycle: assert property (pins.addr_latch_strobe |=> !pins.addr_latch_strobe)
		else $error("address latch strobe longer than one cycle");
	a_ale_one_select: assert property (pins.addr_latch_strobe |-> bus_oe && $onehot(~pins.region_select_n))
		else $error("address latch strobe without one region select");
	a_strobe_min_len: assert property ($fell(strb) |-> slen >= STROBE_MIN)
		else $error("strobe shorter than its minimum");
	a_strobe_no_hold: assert property (strb |-> $onehot(~pins.region_select_n) && pins.bus_released_ack_n)
		else $error("strobe without select or during hold");
	a_read_lanes_free: assert property (!pins.read_strobe_n |-> data_oe == 2'h0)
		else $error("data lanes driven during read strobe");
	a_store_drives_low: assert property (!pins.low_byte_store_strobe_n |-> data_oe[0])
		else $error("store strobe without low lane data");
	a_wait_stretches: assert property ((strb && !wait_request_n) [*6] |=> strb)
		else $error("strobe ended while wait held low");
	a_hold_released: assert property (!pins.bus_released_ack_n |-> !bus_oe && data_oe == 2'h0)
		else $error("outputs driven while bus released");
	a_hold_needs_req: assert property ($fell(pins.bus_released_ack_n) |-> $past(!hold_request_n, 2))
		else $error("hold granted without request");
	a_hold_kept: assert property (!pins.bus_released_ack_n && !hold_request_n |=> !pins.bus_released_ack_n)
		else $error("hold left while request low");
endmodule

bind external_memory_bus_interface ebi_monitor #(.STROBE_MIN(STROBE_MIN)) mon (
	.aclk(aclk),
	.aresetn(aresetn),
	.hold_request_n(hold_request_n),
	.wait_request_n(wait_request_n),
	.pins(pins),
	.bus_oe(bus_oe),
	.data_oe(data_oe)
);

// [tb/test_external_memory_bus_interface.sv]
// Purpose: self-checking bench for the external memory bus interface
// Assumes: registers reached over AXI4-Lite, memory model on the pins
// Notes: each scenario is one task
module test_external_memory_bus_interface import ebi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, boot_mode_pin = 1, byte_width_pin = 0, hold_request_n = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF, slow = 4'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, single = 0, wide = 1, mux = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic bus_oe, wait_request_n;
	wire logic [1:0] s_axi_bresp, s_axi_rresp, data_oe;
	wire logic [31:0] s_axi_rdata;
	wire logic [15:0] data_out, data_in, mem_q;
	wire ext_out_t pins;
	wire logic [2:0] strobes = {pins.read_strobe_n, pins.low_byte_store_strobe_n,
		pins.high_byte_store_strobe_n};
	int n_mismatch = 0, compares = 0, cyc = 0;
	// each lane shows the device while it drives, the memory otherwise
	assign data_in = {data_oe[1] ? data_out[15:8] : mem_q[15:8],
		data_oe[0] ? data_out[7:0] : mem_q[7:0]};
	external_memory_bus_interface #(.STROBE_MIN(6)) dut (.*);
	ext_mem_model far_end (.aclk(aclk), .pins(pins), .data_out(data_out), .data_oe(data_oe),
		.mem_q(mem_q), .wait_request_n(wait_request_n), .single(single), .wide(wide),
		.slow(slow));
	initial forever #25 aclk = ~aclk;
	task give_verdict;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, er);
	endtask
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			d = s_axi_rdata;
			r = s_axi_rresp;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d, e);
		chk(r, 2'h0);
	endtask
	// cmd is {region, word, write}; returns the read data register
	task acc(input logic [3:0] cmd, input logic [23:0] a, input logic [15:0] wd,
		input logic [2:0] es, input int lmin, output logic [31:0] q);
		logic [1:0] r;
		int n;
		axw(8'h04, {8'h00, a}, 2'h0);
		axw(8'h08, {16'h0000, wd}, 2'h0);
		axw(8'h0C, {28'h0000000, cmd}, 2'h0);
		while (pins.addr_latch_strobe !== 1'h1) @(posedge aclk);
		chk(pins.region_select_n, 4'(~(4'h1 << cmd[3:2])));
		chk(pins.top_address_bit, !a[23]);
		chk(pins.addr, a[22:0]);
		if (mux) chk({data_oe, data_out}, {2'h3, a[15:0]});
		@(posedge aclk);
		chk(strobes, es);
		n = 0;
		while (strobes !== 3'h7) begin
			n++;
			@(posedge aclk);
		end
		chk(n >= lmin, 1'h1);
		do begin
			axr(8'h10, q, r);
		end while (q[0] !== 1'h0);
		axr(8'h14, q, r);
	endtask
	task t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rdc(8'h00, 32'h4);
		rdc(8'h10, 32'hC);
		rdc(8'h0C, 32'h0);
		axr(8'h18, d, r);
		chk(r, 2'h2);
		chk(d, 32'h0);
		axw(8'h1C, 32'h1, 2'h2);
	endtask
	task t_sep16;
		logic [31:0] q;
		axw(8'h00, 32'h4, 2'h0);
		acc(4'hF, 24'h800010, 16'hA55A, 3'h4, 6, q);
		acc(4'hE, 24'h800010, 16'h0, 3'h3, 6, q);
		chk(q[15:0], 16'hA55A);
		acc(4'hD, 24'h800013, 16'h3C, 3'h6, 6, q);
		acc(4'hC, 24'h800013, 16'h0, 3'h3, 6, q);
		chk(q[7:0], 8'h3C);
	endtask
	task t_mux16;
		logic [31:0] q;
		axw(8'h00, 32'h6, 2'h0);
		mux = 1;
		acc(4'h3, 24'h000124, 16'h1234, 3'h4, 6, q);
		acc(4'h2, 24'h000124, 16'h0, 3'h3, 6, q);
		chk(q[15:0], 16'h1234);
		mux = 0;
	endtask
	task t_single8;
		logic [31:0] q;
		byte_width_pin <= 1'h1;
		wide = 0;
		repeat (8) @(posedge aclk);
		rdc(8'h10, 32'h4);
		axw(8'h00, 32'h5, 2'h0);
		single = 1;
		acc(4'hD, 24'h800031, 16'h96, 3'h4, 6, q);
		acc(4'hC, 24'h800031, 16'h0, 3'h2, 6, q);
		chk(q[7:0], 8'h96);
		byte_width_pin <= 1'h0;
		wide = 1;
		single = 0;
		repeat (8) @(posedge aclk);
	endtask
	task t_wait;
		logic [31:0] q;
		axw(8'h00, 32'h4, 2'h0);
		slow = 4'h8;
		acc(4'hE, 24'h800010, 16'h0, 3'h3, 10, q);
		chk(q[15:0], 16'hA55A);
		slow = 4'h0;
	endtask
	task t_hold;
		int n;
		axw(8'h0C, 32'hF, 2'h0);
		hold_request_n <= 1'h0;
		n = 0;
		while (pins.bus_released_ack_n !== 1'h0) begin
			n++;
			@(posedge aclk);
		end
		chk(n > 6, 1'h1);
		chk({bus_oe, data_oe}, 3'h0);
		rdc(8'h10, 32'hE);
		repeat (6) begin
			@(posedge aclk);
			chk(pins.bus_released_ack_n, 1'h0);
		end
		hold_request_n <= 1'h1;
		n = 0;
		while (pins.bus_released_ack_n !== 1'h1) begin
			n++;
			@(posedge aclk);
		end
		chk(n < 10, 1'h1);
	endtask
	task t_boot;
		int n;
		aresetn <= 1'h0;
		boot_mode_pin <= 1'h0;
		repeat (8) @(posedge aclk);
		chk({pins.bus_released_ack_n, bus_oe, data_oe, pins.region_select_n,
			pins.read_strobe_n, pins.top_address_bit}, 10'h23F);
		aresetn <= 1'h1;
		repeat (8) @(posedge aclk);
		rdc(8'h10, 32'h8);
		axw(8'h0C, 32'h1, 2'h0);
		n = 0;
		repeat (30) begin
			@(posedge aclk);
			if (pins.addr_latch_strobe === 1'h1) n++;
		end
		chk(n, 0);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (8) @(posedge aclk);
		t_regs;
		t_sep16;
		t_mux16;
		t_single8;
		t_wait;
		t_hold;
		t_boot;
		give_verdict;
	end
endmodule
